// ==== rtl/acfm_pkg.sv ====
// constants and types shared by the channel alarm and fault monitor
package acfm_pkg;
    localparam int ACFM_NCH = 8;
    localparam int ACFM_CHW = 3;
    // thresholds and saturation limits, signed 16-bit, with signed 24-bit copies for the wide compares
    localparam logic signed [15:0] ACFM_POS_MAX = 16'sh7FFF;
    localparam logic signed [15:0] ACFM_NEG_MAX = -16'sh7FFF;
    localparam logic signed [23:0] ACFM_POS_MAX_W = 24'sh007FFF;
    localparam logic signed [23:0] ACFM_NEG_MAX_W = -24'sh007FFF;
    localparam logic [15:0] ACFM_HI_RST = 16'h7FFF;
    localparam logic [15:0] ACFM_LO_RST = 16'h8001;
    localparam logic [15:0] ACFM_CFG_RST = 16'h0000;
    // open wire: loop current below this many microamps
    localparam logic [15:0] ACFM_OPEN_UA = 16'h07D0;
    // configuration word bits (zero based: bit 8 is index 7)
    localparam int ACFM_CFG_CUR = 0;
    localparam int ACFM_CFG_RPT_DIS = 7;
    localparam int ACFM_CFG_IRQ_EN = 12;
    // fault vector positions
    localparam int ACFM_NFLT = 3;
    localparam int ACFM_FLT_OVER = 0;
    localparam int ACFM_FLT_UNDER = 1;
    localparam int ACFM_FLT_OPEN = 2;
    // register map: channel register word offsets, global byte addresses; channel block stride 0x10
    localparam logic [1:0] ACFM_REG_CFG = 2'h0;
    localparam logic [1:0] ACFM_REG_HI = 2'h1;
    localparam logic [1:0] ACFM_REG_LO = 2'h2;
    localparam logic [1:0] ACFM_REG_STAT = 2'h3;
    localparam logic [7:0] ACFM_REG_GSTAT = 8'h80;
    localparam logic [7:0] ACFM_REG_GCTL = 8'h84;
    localparam logic [7:0] ACFM_REG_EXPECT = 8'h88;
    localparam logic [7:0] ACFM_EXPECT_RST = 8'h00;
    typedef enum logic [1:0] {
        ACFM_WAIT = 2'b00,
        ACFM_RUN = 2'b01,
        ACFM_HALT = 2'b10
    } acfm_state_t;
endpackage

// ==== rtl/acfm_smp_if.sv ====
// per-channel sample carrier from the front stage to the checkers
`timescale 1ns/1ps
`default_nettype none
interface acfm_smp_if;
    logic vld;
    logic signed [15:0] value;
    logic [2:0] flt;
    logic clr;
    modport src (output vld, output value, output flt, output clr);
    modport dst (input vld, input value, input flt, input clr);
endinterface
`default_nettype wire

// ==== rtl/acfm_alarm.sv ====
// threshold comparator for one channel
`timescale 1ns/1ps
`default_nettype none
module acfm_alarm
    import acfm_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // sample and settings
    acfm_smp_if.dst smp,
    input wire logic signed [15:0] i_hi,
    input wire logic signed [15:0] i_lo,
    input wire logic i_irq_en,
    // results
    output logic o_high,
    output logic o_low,
    output logic o_irq
);
    wire hi_on = (i_hi != ACFM_POS_MAX); // RULE_07
    wire lo_on = (i_lo != ACFM_NEG_MAX); // RULE_07
    wire above = hi_on && (smp.value > i_hi); // RULE_01 RULE_21
    wire below = lo_on && (smp.value < i_lo); // RULE_01 RULE_21
    // one event per entry, not per sample while beyond
    wire ev = (above && !o_high) || (below && !o_low); // RULE_02
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_high <= 1'b0;
            o_low <= 1'b0;
            o_irq <= 1'b0;
        end else if (smp.clr) begin
            o_high <= 1'b0;
            o_low <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_irq <= smp.vld && ev && i_irq_en; // RULE_04
            if (smp.vld) begin
                o_high <= above; // RULE_01
                o_low <= below; // RULE_01
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/acfm_fault.sv ====
// fault contact and once-per-occurrence report for one channel
`timescale 1ns/1ps
`default_nettype none
module acfm_fault
    import acfm_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // sample and settings
    acfm_smp_if.dst smp,
    input wire logic i_rpt_dis,
    // results
    output logic o_fault,
    output logic o_healthy,
    output logic o_report
);
    logic [ACFM_NFLT-1:0] seen;
    // a condition reports only on its rising edge
    wire [ACFM_NFLT-1:0] fresh = smp.flt & ~seen; // RULE_09
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            seen <= '0;
            o_fault <= 1'b0;
            o_healthy <= 1'b0;
            o_report <= 1'b0;
        end else if (smp.clr) begin
            seen <= '0;
            o_fault <= 1'b0;
            o_healthy <= 1'b0;
            o_report <= 1'b0;
        end else begin
            o_report <= smp.vld && (|fresh) && !i_rpt_dis; // RULE_09
            if (smp.vld) begin
                seen <= smp.flt;
                o_fault <= |smp.flt; // RULE_10
                o_healthy <= ~(|smp.flt); // RULE_10
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/acfm_top.sv ====
// per-channel alarm and fault monitor with avalon-mm registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] above high or below low energizes contact
// [RULE_02] one alarm event per threshold crossing
// [RULE_03] alarms never alter reported value
// [RULE_04] alarm event interrupts when channel enables it
// [RULE_05] host refreshes channel data before handler
// [RULE_06] host keeps thresholds in range, high above low
// [RULE_07] extreme threshold disables that alarm
// [RULE_08] thresholds default to plus/minus 32767
// [RULE_09] each fault reported once per occurrence
// [RULE_10] any fault sets fault, clears healthy
// [RULE_11] scaled above 32767 saturates, flags overrange
// [RULE_12] converter above span flags overrange
// [RULE_13] scaled below -32767 saturates, flags underrange
// [RULE_14] converter below span flags underrange
// [RULE_15] current mode below 2mA flags open wire
// [RULE_16] expansion failure flags not responding
// [RULE_17] converter comm failure: interrupt, lamps off, halt
// [RULE_18] zero scaling out of range: error, halt
// [RULE_19] expander probe mismatch reports configuration error
// [RULE_20] config bit 8 disables reports, 13 enables irq
// [RULE_21] checks run per sample, signed 16-bit
module acfm_top
    import acfm_pkg::*;
#(
    parameter int NCH = ACFM_NCH
)(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // samples from the converter stage
    input wire logic i_smp_vld,
    input wire logic [ACFM_CHW-1:0] i_smp_chan,
    input wire logic signed [23:0] i_smp_scaled,
    input wire logic i_smp_span_hi,
    input wire logic i_smp_span_lo,
    input wire logic [15:0] i_smp_loop_ua,
    // module health events
    input wire logic i_exp_no_resp,
    input wire logic i_adc_comm_fail,
    input wire logic i_zero_vld,
    input wire logic signed [23:0] i_zero_eng,
    input wire logic i_probe_vld,
    input wire logic [1:0] i_probe_range,
    input wire logic [3:0] i_probe_count,
    // reported value
    output logic o_value_vld,
    output logic [ACFM_CHW-1:0] o_value_chan,
    output logic signed [15:0] o_value,
    // channel contacts and events
    output logic [NCH-1:0] o_high_limit_contact,
    output logic [NCH-1:0] o_low_limit_contact,
    output logic [NCH-1:0] o_fault_contact,
    output logic [NCH-1:0] o_channel_healthy_contact,
    output logic [NCH-1:0] o_alarm_irq,
    output logic [NCH-1:0] o_fault_report,
    // module level
    output logic o_fault_irq,
    output logic o_board_ok,
    output logic o_port_ok
);
    ////////////////////////////////////////////////////////////////////////
    // state and storage
    acfm_state_t state;
    acfm_state_t next_state;
    logic [15:0] cfg [NCH];
    logic [15:0] hi [NCH];
    logic [15:0] lo [NCH];
    logic [15:0] val_mem [NCH];
    logic [7:0] expect_cfg;
    logic comm_err;
    logic scale_err;
    logic cfg_err;
    logic s_vld;
    logic [ACFM_CHW-1:0] s_chan;
    logic signed [15:0] s_val;
    logic [ACFM_NFLT-1:0] s_flt;

    ////////////////////////////////////////////////////////////////////////
    // front stage: saturation and range faults
    wire run = (state == ACFM_RUN);
    wire take = i_smp_vld && run;
    wire sat_hi = (i_smp_scaled > ACFM_POS_MAX_W); // RULE_11
    wire sat_lo = (i_smp_scaled < ACFM_NEG_MAX_W); // RULE_13
    wire signed [15:0] sat_val = sat_hi ? ACFM_POS_MAX : // RULE_11
        sat_lo ? ACFM_NEG_MAX : i_smp_scaled[15:0]; // RULE_13
    wire cur_mode = cfg[i_smp_chan][ACFM_CFG_CUR];
    wire f_over = sat_hi || i_smp_span_hi; // RULE_11 RULE_12
    wire f_under = sat_lo || i_smp_span_lo; // RULE_13 RULE_14
    wire f_open = cur_mode && (i_smp_loop_ua < ACFM_OPEN_UA); // RULE_15
    wire [ACFM_NFLT-1:0] flt_vec = {f_open, f_under, f_over};

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s_vld <= 1'b0;
            s_chan <= '0;
            s_val <= '0;
            s_flt <= '0;
        end else begin
            s_vld <= take;
            if (take) begin
                s_chan <= i_smp_chan;
                s_val <= sat_val;
                s_flt <= flt_vec;
            end
        end
    end

    // reported value path: the comparators only read s_val
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_value_vld <= 1'b0;
            o_value_chan <= '0;
            o_value <= '0;
        end else begin
            o_value_vld <= s_vld; // RULE_03
            if (s_vld) begin
                o_value_chan <= s_chan;
                o_value <= s_val; // RULE_03
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel checkers
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        acfm_smp_if smp ();
        assign smp.vld = s_vld && (s_chan == ACFM_CHW'(c));
        assign smp.value = s_val;
        assign smp.flt = s_flt;
        // a halted module drops every contact
        assign smp.clr = (state == ACFM_HALT); // RULE_17 RULE_18
        acfm_alarm u_alarm (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .smp(smp),
            .i_hi(hi[c]),
            .i_lo(lo[c]),
            .i_irq_en(cfg[c][ACFM_CFG_IRQ_EN]), // RULE_20
            .o_high(o_high_limit_contact[c]),
            .o_low(o_low_limit_contact[c]),
            .o_irq(o_alarm_irq[c])
        );
        acfm_fault u_fault (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .smp(smp),
            .i_rpt_dis(cfg[c][ACFM_CFG_RPT_DIS]), // RULE_20
            .o_fault(o_fault_contact[c]),
            .o_healthy(o_channel_healthy_contact[c]),
            .o_report(o_fault_report[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // module state: wait for start, run, halt on fatal errors
    wire zero_bad = i_zero_vld && ((i_zero_eng > ACFM_POS_MAX_W) ||
        (i_zero_eng < ACFM_NEG_MAX_W)); // RULE_18
    wire comm_hit = i_adc_comm_fail && (state != ACFM_HALT); // RULE_17
    wire scale_hit = zero_bad && (state != ACFM_HALT); // RULE_18
    wire probe_bad = i_probe_vld &&
        ({i_probe_count, 2'b00, i_probe_range} != expect_cfg); // RULE_19

    ////////////////////////////////////////////////////////////////////////
    // register bus
    wire req = (i_avs_read || i_avs_write) && o_avs_waitrequest;
    wire wr_go = i_avs_write && !o_avs_waitrequest;
    wire lanes_ok = (i_avs_byteenable[1:0] == 2'b11);
    wire in_ch = !i_avs_address[7];
    wire [ACFM_CHW-1:0] a_ch = i_avs_address[4+ACFM_CHW-1:4];
    wire a_ch_ok = in_ch && (32'(a_ch) < NCH) &&
        (i_avs_address[1:0] == 2'b00);
    wire [1:0] a_reg = i_avs_address[3:2];
    wire start_wr = wr_go && lanes_ok && (i_avs_address == ACFM_REG_GCTL) &&
        i_avs_writedata[0];

    always_comb begin
        next_state = state;
        case (state)
            ACFM_WAIT: begin
                if (comm_hit || scale_hit) begin
                    next_state = ACFM_HALT;
                end else if (start_wr) begin
                    next_state = ACFM_RUN;
                end
            end
            ACFM_RUN: begin
                if (comm_hit || scale_hit) begin
                    next_state = ACFM_HALT; // RULE_17 RULE_18
                end
            end
            ACFM_HALT: next_state = ACFM_HALT;
            default: next_state = ACFM_WAIT;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= ACFM_WAIT;
            comm_err <= 1'b0;
            scale_err <= 1'b0;
            cfg_err <= 1'b0;
            o_fault_irq <= 1'b0;
        end else begin
            state <= next_state;
            // message goes out before the halt takes hold
            o_fault_irq <= comm_hit || scale_hit; // RULE_17 RULE_18
            if (comm_hit) begin
                comm_err <= 1'b1; // RULE_17
            end
            if (scale_hit) begin
                scale_err <= 1'b1; // RULE_18
            end
            if (probe_bad) begin
                cfg_err <= 1'b1; // RULE_19
            end
        end
    end

    // lamps: dark while halted
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_board_ok <= 1'b0;
            o_port_ok <= 1'b0;
        end else begin
            o_board_ok <= run && !cfg_err; // RULE_17 RULE_19
            o_port_ok <= run && !i_exp_no_resp; // RULE_16
        end
    end

    wire [31:0] stat_word = {13'h0, o_fault_contact[a_ch],
        o_low_limit_contact[a_ch], o_high_limit_contact[a_ch],
        val_mem[a_ch]};
    wire [31:0] gstat_word = {26'h0, i_exp_no_resp, cfg_err,
        scale_err, comm_err, (state == ACFM_HALT), run}; // RULE_16
    wire [31:0] ch_word = (a_reg == ACFM_REG_CFG) ? {16'h0000, cfg[a_ch]} :
        (a_reg == ACFM_REG_HI) ? {16'h0000, hi[a_ch]} :
        (a_reg == ACFM_REG_LO) ? {16'h0000, lo[a_ch]} : stat_word;
    wire [31:0] rd_mux = a_ch_ok ? ch_word :
        (i_avs_address == ACFM_REG_GSTAT) ? gstat_word :
        (i_avs_address == ACFM_REG_EXPECT) ? {24'h000000, expect_cfg} :
        32'h00000000;

    // answer one cycle after the request is seen
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end else begin
            o_avs_waitrequest <= !req;
            if (req && i_avs_read) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    // channel register writes land only while the module is not halted
    wire cw = wr_go && lanes_ok && a_ch_ok && (state != ACFM_HALT);
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            expect_cfg <= ACFM_EXPECT_RST;
            for (int i = 0; i < NCH; i++) begin
                cfg[i] <= ACFM_CFG_RST;
                hi[i] <= ACFM_HI_RST; // RULE_08
                lo[i] <= ACFM_LO_RST; // RULE_08
                val_mem[i] <= 16'h0000;
            end
        end else begin
            if (wr_go && lanes_ok && (i_avs_address == ACFM_REG_EXPECT)) begin
                expect_cfg <= i_avs_writedata[7:0];
            end
            if (cw && (a_reg == ACFM_REG_CFG)) begin
                cfg[a_ch] <= i_avs_writedata[15:0]; // RULE_20
            end
            // range and ordering of thresholds is the host's job
            if (cw && (a_reg == ACFM_REG_HI)) begin
                hi[a_ch] <= i_avs_writedata[15:0]; // RULE_06
            end
            if (cw && (a_reg == ACFM_REG_LO)) begin
                lo[a_ch] <= i_avs_writedata[15:0]; // RULE_06
            end
            if (s_vld) begin
                val_mem[s_chan] <= s_val; // RULE_05
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/acfm_props.sv ====
// port checker for the channel alarm and fault monitor
`timescale 1ns/1ps
`default_nettype none
module acfm_props
    import acfm_pkg::*;
#(
    parameter int NCH = ACFM_NCH
)(
    // clock, reset and bus
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    // samples and results
    input wire logic i_smp_vld,
    input wire logic o_value_vld,
    input wire logic signed [15:0] o_value,
    input wire logic [NCH-1:0] o_high_limit_contact,
    input wire logic [NCH-1:0] o_low_limit_contact,
    input wire logic [NCH-1:0] o_fault_contact,
    input wire logic [NCH-1:0] o_channel_healthy_contact,
    input wire logic [NCH-1:0] o_alarm_irq,
    input wire logic [NCH-1:0] o_fault_report,
    input wire logic o_fault_irq,
    input wire logic o_board_ok
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    property p_ans;
        (i_avs_read || i_avs_write) && o_avs_waitrequest
            |=> !o_avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("bus answer late");
    property p_wait_one; $fell(o_avs_waitrequest) |=> o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low long");
    property p_sat;
        o_value_vld |-> o_value >= ACFM_NEG_MAX && o_value <= ACFM_POS_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("unclamped");
    property p_lat; o_value_vld |-> $past(i_smp_vld, 2); endproperty
    a_lat: assert property (p_lat) else $error("value, no sample");
    // an event only where a contact has just risen
    property p_evt;
        (o_alarm_irq & ~((o_high_limit_contact & ~$past(o_high_limit_contact))
        | (o_low_limit_contact & ~$past(o_low_limit_contact)))) == '0;
    endproperty
    a_evt: assert property (p_evt) else $error("repeated event");
    property p_irq; o_alarm_irq != '0 |-> $past(i_smp_vld, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq, no sample");
    property p_cpl; (o_fault_contact & o_channel_healthy_contact) == '0;
    endproperty
    a_cpl: assert property (p_cpl) else $error("fault and healthy");
    property p_rpt; (o_fault_report & ~o_fault_contact) == '0; endproperty
    a_rpt: assert property (p_rpt) else $error("report, no fault");
    property p_hilo; (o_high_limit_contact & o_low_limit_contact) == '0;
    endproperty
    a_hilo: assert property (p_hilo) else $error("high and low");
    property p_halt;
        o_fault_irq |=> (o_high_limit_contact == '0 && o_fault_contact == '0
        && o_low_limit_contact == '0 && !o_board_ok) [*3];
    endproperty
    a_halt: assert property (p_halt)
        else $error("lamps on after halt");
endmodule
bind acfm_top acfm_props #(.NCH(NCH)) i_acfm_props (.*);
`default_nettype wire

// ==== testbench/acfm_host_model.sv ====
// host side avalon-mm master model for the monitor registers
`timescale 1ns/1ps
`default_nettype none
module acfm_host_model
    import acfm_pkg::*;
(
    // clock
    input wire logic i_mclk,
    // avalon-mm master
    output logic [7:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable,
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest
);
    initial begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
        o_byteenable = 4'hF;
    end
    // request held until waitrequest is seen low at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge i_mclk);
        o_address <= a;
        o_writedata <= d;
        o_write <= w;
        o_read <= !w;
        do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_write <= 1'b0;
        o_read <= 1'b0;
        // stale data must not look valid
        o_writedata <= ~d;
    endtask
    task automatic set_chan(input int c, input logic [15:0] f,
            input logic signed [15:0] h, input logic signed [15:0] l);
        logic [31:0] q;
        if (h <= l || l < ACFM_NEG_MAX) begin
            h = ACFM_POS_MAX;
            l = ACFM_NEG_MAX;
        end
        xfer(1'b1, 8'(c * 16), {16'h0, f}, q);
        xfer(1'b1, 8'(c * 16 + 4), {16'h0, h}, q);
        xfer(1'b1, 8'(c * 16 + 8), {16'h0, l}, q);
    endtask
    // channel data refreshed before any handler runs
    task automatic refresh(input int c, output logic [31:0] q);
        xfer(1'b0, 8'(c * 16 + 12), 32'h0, q);
    endtask
endmodule
`default_nettype wire

// ==== testbench/test_analog_channel_alarm_fault_monitor.sv ====
// self-checking bench for the channel alarm and fault monitor
`timescale 1ns/1ps
`default_nettype none
module test_analog_channel_alarm_fault_monitor;
    import acfm_pkg::*;
    typedef struct {logic [2:0] c; logic signed [15:0] v;
        logic h, l, irq, flt, rpt;} acfm_exp_t;
    logic i_mclk = 0, i_rst = 1, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [7:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [3:0] i_avs_byteenable;
    logic i_smp_vld = 0, i_smp_span_hi = 0, i_smp_span_lo = 0;
    logic i_exp_no_resp = 0, i_adc_comm_fail = 0, i_zero_vld = 0;
    logic i_probe_vld = 0, o_value_vld, o_fault_irq, o_board_ok, o_port_ok;
    logic [2:0] i_smp_chan = 0, o_value_chan;
    logic signed [23:0] i_smp_scaled = 0, i_zero_eng = 0;
    logic [15:0] i_smp_loop_ua = 0;
    logic [1:0] i_probe_range = 0;
    logic [3:0] i_probe_count = 0;
    logic signed [15:0] o_value;
    logic [7:0] o_high_limit_contact, o_low_limit_contact, o_fault_contact;
    logic [7:0] o_channel_healthy_contact, o_alarm_irq, o_fault_report;
    logic [15:0] cfg_m [8];
    logic signed [15:0] hi_m [8], lo_m [8], last_v [8];
    logic ph [8], pl [8];
    logic [2:0] pf [8];
    acfm_exp_t exq [$];
    int err_count = 0, num_checks = 0, seed = 32'he088, cyc = 0;
    localparam logic [7:0] RA [5] = '{8'h00, 8'h04, 8'h08, 8'h8C, 8'h80};
    localparam logic [31:0] RV [5] = '{32'h0, 32'h7FFF, 32'h8001, 32'h0,
        32'h0};
    localparam int CV [10] = '{101, 200, 100, 101, -101, -200, 32767, 32768,
        -32767, -32768};
    initial forever #10 i_mclk = ~i_mclk;
    acfm_host_model i_acfm_host_model (.i_mclk, .o_address(i_avs_address),
        .o_read(i_avs_read), .o_write(i_avs_write),
        .o_writedata(i_avs_writedata), .o_byteenable(i_avs_byteenable),
        .i_readdata(o_avs_readdata), .i_waitrequest(o_avs_waitrequest));
    acfm_top i_acfm_top (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic signed [15:0] sat(logic signed [23:0] x);
        if (x > ACFM_POS_MAX_W) return ACFM_POS_MAX;
        if (x < ACFM_NEG_MAX_W) return ACFM_NEG_MAX;
        return x[15:0];
    endfunction
    task automatic do_reset();
        i_rst <= 1'h1;
        for (int c = 0; c < 8; c++) begin
            cfg_m[c] = ACFM_CFG_RST;
            hi_m[c] = ACFM_HI_RST;
            lo_m[c] = ACFM_LO_RST;
            ph[c] = 0;
            pl[c] = 0;
            pf[c] = 0;
        end
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'h0;
    endtask
    task automatic cfgch(int c, logic [15:0] f, logic signed [15:0] h,
            logic signed [15:0] l);
        i_acfm_host_model.set_chan(c, f, h, l);
        cfg_m[c] = f;
        hi_m[c] = h;
        lo_m[c] = l;
    endtask
    // expectation fixed at launch
    task automatic send(logic [2:0] c, logic signed [23:0] x, logic sh,
            logic sl, logic [15:0] u);
        acfm_exp_t e;
        logic [2:0] f;
        f = {cfg_m[c][ACFM_CFG_CUR] && u < ACFM_OPEN_UA,
            x < ACFM_NEG_MAX_W || sl, x > ACFM_POS_MAX_W || sh};
        e.c = c;
        e.v = sat(x);
        e.h = e.v > hi_m[c];
        e.l = e.v < lo_m[c];
        e.irq = cfg_m[c][ACFM_CFG_IRQ_EN] && (e.h && !ph[c] || e.l && !pl[c]);
        e.flt = |f;
        e.rpt = !cfg_m[c][ACFM_CFG_RPT_DIS] && |(f & ~pf[c]);
        ph[c] = e.h;
        pl[c] = e.l;
        pf[c] = f;
        last_v[c] = e.v;
        exq.push_back(e);
        @(posedge i_mclk);
        i_smp_vld <= 1'h1;
        i_smp_chan <= c;
        i_smp_scaled <= x;
        i_smp_span_hi <= sh;
        i_smp_span_lo <= sl;
        i_smp_loop_ua <= u;
    endtask
    task automatic idle();
        @(posedge i_mclk);
        i_smp_vld <= 1'h0;
    endtask
    always @(negedge i_mclk) begin
        acfm_exp_t e;
        if (o_value_vld === 1'h1) begin
            e = exq.pop_front();
            chk("chan", e.c, o_value_chan);
            chk("value", e.v, o_value);
            chk("high", e.h, o_high_limit_contact[e.c]);
            chk("low", e.l, o_low_limit_contact[e.c]);
            chk("irq", 32'(e.irq) << e.c, o_alarm_irq);
            chk("fault", {e.flt, !e.flt}, {o_fault_contact[e.c],
                o_channel_healthy_contact[e.c]});
            chk("report", 32'(e.rpt) << e.c, o_fault_report);
        end
    end
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        int t;
        do_reset();
        foreach (RA[i]) begin
            i_acfm_host_model.xfer(1'h0, RA[i], 32'h0, q);
            chk("reset reg", RV[i], q);
        end
        $display("test reset values done");
        i_acfm_host_model.xfer(1'h1, ACFM_REG_EXPECT, 32'h21, q);
        cfgch(0, 16'h1000, 100, -100);
        cfgch(1, 16'h1081, ACFM_POS_MAX, 0);
        cfgch(2, 16'h1000, 0, ACFM_NEG_MAX);
        for (int c = 3; c < 8; c++) begin
            t = $random(seed) % 20000;
            cfgch(c, 16'($random(seed)) & 16'h1081, 16'(t + 50), 16'(t - 50));
        end
        i_acfm_host_model.xfer(1'h1, ACFM_REG_GCTL, 32'h1, q);
        foreach (CV[i]) send(0, 24'(CV[i]), 0, 0, 16'h0FA0);
        idle();
        repeat (4) @(posedge i_mclk);
        i_acfm_host_model.refresh(0, q);
        chk("stat", $unsigned(last_v[0]), q[15:0]);
        $display("test threshold corners done");
        repeat (300) begin
            send(3'($random(seed)), 24'($random(seed) % 45000),
                ($random(seed) & 15) == 0, ($random(seed) & 15) == 0,
                16'($random(seed)) & 16'h0FFF);
            if (($random(seed) & 3) == 0) idle();
        end
        idle();
        repeat (4) @(posedge i_mclk);
        $display("test random samples done");
        chk("board ok", 1, o_board_ok);
        chk("port ok", 1, o_port_ok);
        i_probe_vld <= 1'h1;
        i_probe_range <= 2'h1;
        i_probe_count <= 4'h3;
        @(posedge i_mclk);
        i_probe_vld <= 1'h0;
        i_exp_no_resp <= 1'h1;
        repeat (3) @(posedge i_mclk);
        chk("board ok", 0, o_board_ok);
        chk("port ok", 0, o_port_ok);
        i_exp_no_resp <= 1'h0;
        $display("test expander faults done");
        for (int k = 0; k < 2; k++) begin
            do_reset();
            i_acfm_host_model.xfer(1'h1, ACFM_REG_GCTL, 32'h1, q);
            cfgch(0, 16'h0000, 100, -100);
            send(0, 200, 0, 0, 16'h0);
            idle();
            repeat (4) @(posedge i_mclk);
            i_zero_vld <= !k[0];
            i_zero_eng <= 24'sd40000;
            i_adc_comm_fail <= k[0];
            @(posedge i_mclk);
            i_zero_vld <= 1'h0;
            i_adc_comm_fail <= 1'h0;
            @(negedge i_mclk);
            chk("fault irq", 1, o_fault_irq);
            @(posedge i_mclk);
            i_smp_vld <= 1'h1;
            @(posedge i_mclk);
            i_smp_vld <= 1'h0;
            repeat (3) @(negedge i_mclk);
            chk("halt lamps", 0, {o_value_vld, o_high_limit_contact[0],
                o_board_ok});
        end
        $display("test halt done");
        results();
    end
endmodule
`default_nettype wire
